// [bench/keypad_scan_order_and_irq_bench.sv]
// Self-checking bench for the keypad scan order and interrupt block
`timescale 1ns/100ps
`include "kps_defines.svh"
module keypad_scan_order_and_irq_bench
   import kps_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   kps_axi_req_t req = '0;
   kps_axi_rsp_t rsp;
   logic tick = 1'b0;
   logic step_in = 1'b0;
   logic key;
   logic [4:0] col;
   logic [5:0] rows;
   logic irq;
   logic [31:0] rd_d;
   logic [1:0] rd_r;
   logic [3:0] strb = 4'hf;
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;

   always #12.5 aclk = ~aclk;

   kps_scan_ctrl i_kps_scan_ctrl (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .key_found_in(key), .clock_tick_in(tick), .scan_step_in(step_in), .column_drive(col),
      .row_enable(rows), .irq(irq));
   kps_keypad_model i_kps_keypad_model (.aclk(aclk), .aresetn(aresetn), .column_drive(col),
      .row_enable(rows), .key_found(key));

   task automatic stop_test;
      $display("Checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         stop_test;
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cy(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Decisions are taken at the falling edge, where the answer is settled
   task automatic wr(input logic [15:0] ix, input logic [7:0] d, input logic [1:0] er);
      logic done;
      logic a;
      logic w;
      done = 1'b0;
      @(posedge aclk);
      req.awaddr <= {ix, 2'b00};
      req.awvalid <= 1'b1;
      req.wdata <= {24'h0, d};
      req.wstrb <= strb;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      while (!done) begin
         @(negedge aclk);
         a = req.awvalid && rsp.awready;
         w = req.wvalid && rsp.wready;
         done = rsp.bvalid;
         if (done) chk("bresp", 32'(er), 32'(rsp.bresp));
         @(posedge aclk);
         if (a) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
         if (done) req.bready <= 1'b0;
      end
   endtask

   // Optional clock tick lands on the same edge that takes the read
   task automatic rd(input logic [15:0] ix, input logic t);
      logic done;
      logic a;
      done = 1'b0;
      @(posedge aclk);
      req.araddr <= {ix, 2'b00};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      tick <= t;
      while (!done) begin
         @(negedge aclk);
         a = req.arvalid && rsp.arready;
         done = rsp.rvalid;
         rd_d = rsp.rdata;
         rd_r = rsp.rresp;
         @(posedge aclk);
         tick <= 1'b0;
         if (a) req.arvalid <= 1'b0;
         if (done) req.rready <= 1'b0;
      end
   endtask

   task automatic rc(input logic [15:0] ix, input logic [7:0] e);
      rd(ix, 1'b0);
      chk("rdata", {24'h0, e}, rd_d);
      chk("rresp", 32'(`KPS_RESP_OKAY), 32'(rd_r));
   endtask

   // Pulse scan step (s=1) or clock tick (s=0), then let the effect settle
   task automatic pls(input logic s);
      @(posedge aclk);
      if (s) step_in <= 1'b1;
      else tick <= 1'b1;
      @(posedge aclk);
      step_in <= 1'b0;
      tick <= 1'b0;
      cy(6);
      @(negedge aclk);
   endtask

   task automatic t_reset;
      rc(`KPS_IDX_SIZE, 8'h00);
      rc(`KPS_IDX_ORDL, 8'h00);
      rc(`KPS_IDX_ORDH, 8'h00);
      rc(`KPS_IDX_ICTL, 8'h00);
      wr(`KPS_IDX_SIZE, 8'hff, `KPS_RESP_OKAY);
      rc(`KPS_IDX_SIZE, 8'h3f);
      // Low byte lane off: the write is answered but changes nothing
      strb = 4'he;
      wr(`KPS_IDX_SIZE, 8'h00, `KPS_RESP_OKAY);
      strb = 4'hf;
      rc(`KPS_IDX_SIZE, 8'h3f);
      wr(`KPS_IDX_ORDH, 8'hff, `KPS_RESP_OKAY);
      rc(`KPS_IDX_ORDH, 8'h7f);
      wr(`KPS_IDX_ICTL, 8'hff, `KPS_RESP_OKAY);
      rc(`KPS_IDX_ICTL, 8'h22);
      chk("column_drive", 32'h0, 32'(col));
      chk("row_enable", 32'h0, 32'(rows));
      wr(16'h0200, 8'h55, `KPS_RESP_SLVERR);
      rd(16'h0200, 1'b0);
      chk("unmapped rdata", 32'h0, rd_d);
      chk("unmapped rresp", 32'(`KPS_RESP_SLVERR), 32'(rd_r));
   endtask

   task automatic t_scan;
      logic [2:0] sq [5] = '{3'h3, 3'h1, 3'h4, 3'h0, 3'h2};
      wr(`KPS_IDX_ORDL, 8'h0b, `KPS_RESP_OKAY);
      wr(`KPS_IDX_ORDH, 8'h21, `KPS_RESP_OKAY);
      wr(`KPS_IDX_SIZE, 8'h35, `KPS_RESP_OKAY);
      wr(`KPS_IDX_STAT, 8'h04, `KPS_RESP_OKAY);
      cy(3);
      @(negedge aclk);
      chk("row_enable", 32'h3f, 32'(rows));
      for (int i = 0; i < 6; i++) begin
         chk("column_drive", 32'(5'h1 << sq[i % 5]), 32'(col));
         pls(1'b1);
      end
      rc(`KPS_IDX_ISTS, 8'h04);
      wr(`KPS_IDX_IMSK, 8'h04, `KPS_RESP_OKAY);
      cy(3);
      @(negedge aclk);
      chk("irq masked in", 32'h1, 32'(irq));
      wr(`KPS_IDX_ISTS, 8'h04, `KPS_RESP_OKAY);
      cy(3);
      @(negedge aclk);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(`KPS_IDX_IMSK, 8'h00, `KPS_RESP_OKAY);
      wr(`KPS_IDX_SIZE, 8'h13, `KPS_RESP_OKAY);
      cy(3);
      @(negedge aclk);
      chk("row_enable", 32'h03, 32'(rows));
      chk("column_drive", 32'h02, 32'(col));
      pls(1'b1);
      chk("column_drive", 32'h10, 32'(col));
      pls(1'b1);
      chk("column_drive", 32'h08, 32'(col));
      // Oversized row count clips to six rows; zero columns drives none
      wr(`KPS_IDX_SIZE, 8'h38, `KPS_RESP_OKAY);
      cy(2);
      @(negedge aclk);
      chk("row_enable", 32'h3f, 32'(rows));
      chk("column_drive", 32'h00, 32'(col));
      wr(`KPS_IDX_SIZE, 8'h13, `KPS_RESP_OKAY);
   endtask

   task automatic t_irq;
      wr(`KPS_IDX_ICTL, 8'h22, `KPS_RESP_OKAY);
      i_kps_keypad_model.press(3'h0, 3'h1);
      pls(1'b1);
      chk("irq", 32'h1, 32'(irq));
      rc(`KPS_IDX_ICTL, 8'h23);
      rc(`KPS_IDX_ICTL, 8'h22);
      rc(`KPS_IDX_STAT, 8'h06);
      rc(`KPS_IDX_STAT, 8'h04);
      wr(`KPS_IDX_ORDL, 8'h0b, `KPS_RESP_OKAY);
      wr(`KPS_IDX_ICTL, 8'h20, `KPS_RESP_OKAY);
      i_kps_keypad_model.press(3'h0, 3'h4);
      pls(1'b1);
      chk("irq", 32'h0, 32'(irq));
      rc(`KPS_IDX_ICTL, 8'h21);
      pls(1'b0);
      chk("irq", 32'h1, 32'(irq));
      rc(`KPS_IDX_ICTL, 8'h30);
      rd(`KPS_IDX_ICTL, 1'b1);
      chk("rdata", 32'h20, rd_d);
      rc(`KPS_IDX_ICTL, 8'h30);
   endtask

   initial begin
      cy(2);
      aresetn <= 1'b1;
      t_reset;
      t_scan;
      t_irq;
      stop_test;
   end
endmodule // keypad_scan_order_and_irq_bench

// [bench/kps_keypad_model.sv]
// Behavioural matrix keypad that reports a pressed key once its column and row are scanned
`timescale 1ns/100ps
module kps_keypad_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [4:0] column_drive,
   input wire logic [5:0] row_enable,
   output logic key_found
);
   logic pressed = 1'b0;
   logic [2:0] press_row = 3'h0;
   logic [2:0] press_col = 3'h0;
   logic hit_q;
   wire logic hit = pressed && column_drive[press_col] && row_enable[press_row];

   task automatic press(input logic [2:0] r, input logic [2:0] c);
      pressed <= 1'b1;
      press_row <= r;
      press_col <= c;
   endtask

   // One pulse each time the pressed switch becomes scanned
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit_q <= 1'b0;
         key_found <= 1'b0;
      end else begin
         hit_q <= hit;
         key_found <= hit && !hit_q;
      end
   end
endmodule // kps_keypad_model

// [src/kps_defines.svh]
// Register indices, field positions, reset values and bus codes of the keypad scan block
`ifndef KPS_DEFINES_SVH
`define KPS_DEFINES_SVH
`define KPS_ADDR_W 18
`define KPS_IDX_W 16
`define KPS_IDX_STAT 16'h00d4
`define KPS_IDX_SIZE 16'h00d5
`define KPS_IDX_ORDL 16'h00d6
`define KPS_IDX_ORDH 16'h00d7
`define KPS_IDX_ISTS 16'h0100
`define KPS_IDX_IMSK 16'h0101
`define KPS_IDX_ICTL 16'hff94
`define KPS_ROW_MAX 3'h6
`define KPS_COL_MAX 3'h5
`define KPS_STAT_AUTO 2
`define KPS_STAT_KEY 1
`define KPS_ICTL_RTCEN 5
`define KPS_ICTL_RTCF 4
`define KPS_ICTL_KPEN 1
`define KPS_ICTL_KPF 0
`define KPS_EV_KEY 0
`define KPS_EV_RTC 1
`define KPS_EV_WRAP 2
`define KPS_EV_N 3
`define KPS_RST_SIZE 6'h00
`define KPS_RST_ORDL 8'h00
`define KPS_RST_ORDH 7'h00
`define KPS_RESP_OKAY 2'h0
`define KPS_RESP_SLVERR 2'h2
`endif

// [src/kps_pkg.sv]
// Types shared by the keypad scan order and interrupt block
package kps_pkg;
   typedef struct packed {
      logic [17:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [17:0] araddr;
      logic arvalid;
      logic rready;
   } kps_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } kps_axi_rsp_t;

   typedef enum logic [2:0] {
      KPS_SEL_NONE = 3'b000,
      KPS_SEL_STAT = 3'b001,
      KPS_SEL_SIZE = 3'b010,
      KPS_SEL_ORDL = 3'b011,
      KPS_SEL_ORDH = 3'b100,
      KPS_SEL_ISTS = 3'b101,
      KPS_SEL_IMSK = 3'b110,
      KPS_SEL_ICTL = 3'b111
   } kps_sel_t;

   typedef struct packed {
      kps_axi_rsp_t rsp;
      logic aw_got;
      logic w_got;
      logic [15:0] aw_idx;
      logic [7:0] wdata;
      logic wlane;
      logic auto_scan_enable;
      logic key_found_flag;
      logic [2:0] row_count;
      logic [2:0] column_count;
      logic [7:0] order_low;
      logic [6:0] order_high;
      logic clock_irq_enable;
      logic clock_irq_flag;
      logic keypad_irq_enable;
      logic keypad_irq_flag;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic [2:0] slot;
      logic [4:0] column_drive;
      logic [5:0] row_enable;
      logic irq;
   } kps_state_t;
endpackage

// [src/kps_scan_ctrl.sv]
// Keypad scan order, size and interrupt control block with an AXI4-Lite register slave
`timescale 1ns/100ps
`include "kps_defines.svh"

// Overview of operation
// - The size fields have no effect unless automatic scanning is on.
// - Size bits 5:3 give the number of rows scanned, capped at six.
// - Size bits 2:0 give the number of columns scanned, capped at five.
// - A fifteen-bit scan order is kept in two registers as five three-bit slots.
// - In automatic mode the slots are visited first to fifth, up to the column count, driving each named column.
// - Each slot holds the binary index of the column to drive.
// - Slots sit at low 2:0, low 5:3, low 7:6 plus high 0, high 3:1 and high 6:4.
// - Control bit 5 enables the clock interrupt and bit 4 flags it, cleared by a read.
// - Control bit 1 enables the keypad interrupt; when clear keypad events raise none unless interrupt mask bit 0 is set.
// - Control bit 0 is set when a key is found and cleared by a read of the register.
// - The auto scan enable bit selects automatic scanning; when clear firmware scans.
// - The key found flag of the status register is cleared by reading that register.
module kps_scan_ctrl
   import kps_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire kps_axi_req_t axi_req,
   output kps_axi_rsp_t axi_rsp,
   input wire logic key_found_in,
   input wire logic clock_tick_in,
   input wire logic scan_step_in,
   output logic [4:0] column_drive,
   output logic [5:0] row_enable,
   output logic irq
);

   function automatic kps_sel_t kps_decode(input logic [17:0] addr);
      logic [15:0] idx;
      idx = addr[17:2];
      if (idx == `KPS_IDX_STAT) kps_decode = KPS_SEL_STAT;
      else if (idx == `KPS_IDX_SIZE) kps_decode = KPS_SEL_SIZE;
      else if (idx == `KPS_IDX_ORDL) kps_decode = KPS_SEL_ORDL;
      else if (idx == `KPS_IDX_ORDH) kps_decode = KPS_SEL_ORDH;
      else if (idx == `KPS_IDX_ISTS) kps_decode = KPS_SEL_ISTS;
      else if (idx == `KPS_IDX_IMSK) kps_decode = KPS_SEL_IMSK;
      else if (idx == `KPS_IDX_ICTL) kps_decode = KPS_SEL_ICTL;
      else kps_decode = KPS_SEL_NONE;
   endfunction

   // Column index held in a slot
   function automatic logic [2:0] kps_slot_col(input logic [7:0] lo, input logic [6:0] hi,
                                                 input logic [2:0] k);
      case (k)
         3'h0: kps_slot_col = lo[2:0];
         3'h1: kps_slot_col = lo[5:3];
         3'h2: kps_slot_col = {hi[0], lo[7:6]};
         3'h3: kps_slot_col = hi[3:1];
         default: kps_slot_col = hi[6:4];
      endcase
   endfunction

   function automatic logic [2:0] kps_clip(input logic [2:0] n, input logic [2:0] lim);
      kps_clip = (n > lim) ? lim : n;
   endfunction

   kps_state_t s_q;
   kps_state_t s_d;
   kps_sel_t rd_sel;
   kps_sel_t wr_sel;
   logic rd_hs;
   logic [2:0] col_n;
   logic [2:0] row_n;
   logic [2:0] ev;
   logic [2:0] col_idx;

   assign rd_hs = axi_req.arvalid & s_q.rsp.arready;
   assign rd_sel = kps_decode(axi_req.araddr);
   assign wr_sel = kps_decode({s_q.aw_idx, 2'b00});

   always_comb begin
      s_d = s_q;
      ev = '0;
      col_n = '0;
      row_n = '0;
      col_idx = '0;
      // Write channel: address and data taken in either order
      if (axi_req.awvalid && s_q.rsp.awready) begin
         s_d.aw_got = 1'b1;
         s_d.aw_idx = axi_req.awaddr[17:2];
      end
      if (axi_req.wvalid && s_q.rsp.wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = axi_req.wdata[7:0];
         s_d.wlane = axi_req.wstrb[0];
      end
      if (s_q.rsp.bvalid && axi_req.bready) begin
         s_d.rsp.bvalid = 1'b0;
      end
      if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = (wr_sel == KPS_SEL_NONE) ? `KPS_RESP_SLVERR : `KPS_RESP_OKAY;
         if (s_q.wlane) begin
            // Flag bits are read-only; unused bits are dropped
            if (wr_sel == KPS_SEL_STAT) begin
               s_d.auto_scan_enable = s_q.wdata[`KPS_STAT_AUTO];
            end else if (wr_sel == KPS_SEL_SIZE) begin
               s_d.row_count = s_q.wdata[5:3];
               s_d.column_count = s_q.wdata[2:0];
            end else if (wr_sel == KPS_SEL_ORDL) begin
               s_d.order_low = s_q.wdata;
            end else if (wr_sel == KPS_SEL_ORDH) begin
               s_d.order_high = s_q.wdata[6:0];
            end else if (wr_sel == KPS_SEL_ISTS) begin
               s_d.irq_status = s_q.irq_status & ~s_q.wdata[2:0];
            end else if (wr_sel == KPS_SEL_IMSK) begin
               s_d.irq_mask = s_q.wdata[2:0];
            end else if (wr_sel == KPS_SEL_ICTL) begin
               s_d.clock_irq_enable = s_q.wdata[`KPS_ICTL_RTCEN];
               s_d.keypad_irq_enable = s_q.wdata[`KPS_ICTL_KPEN];
            end
         end
      end
      s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
      s_d.rsp.wready = !s_d.w_got && !s_d.rsp.bvalid;
      // Read channel with clear-on-read side effects
      if (s_q.rsp.rvalid && axi_req.rready) begin
         s_d.rsp.rvalid = 1'b0;
      end
      if (rd_hs) begin
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rresp = `KPS_RESP_OKAY;
         s_d.rsp.rdata = '0;
         if (rd_sel == KPS_SEL_STAT) begin
            s_d.rsp.rdata[`KPS_STAT_AUTO] = s_q.auto_scan_enable;
            s_d.rsp.rdata[`KPS_STAT_KEY] = s_q.key_found_flag;
            s_d.key_found_flag = 1'b0;
         end else if (rd_sel == KPS_SEL_SIZE) begin
            s_d.rsp.rdata[5:0] = {s_q.row_count, s_q.column_count};
         end else if (rd_sel == KPS_SEL_ORDL) begin
            s_d.rsp.rdata[7:0] = s_q.order_low;
         end else if (rd_sel == KPS_SEL_ORDH) begin
            s_d.rsp.rdata[6:0] = s_q.order_high;
         end else if (rd_sel == KPS_SEL_ISTS) begin
            s_d.rsp.rdata[2:0] = s_q.irq_status;
         end else if (rd_sel == KPS_SEL_IMSK) begin
            s_d.rsp.rdata[2:0] = s_q.irq_mask;
         end else if (rd_sel == KPS_SEL_ICTL) begin
            s_d.rsp.rdata[`KPS_ICTL_RTCEN] = s_q.clock_irq_enable;
            s_d.rsp.rdata[`KPS_ICTL_RTCF] = s_q.clock_irq_flag;
            s_d.rsp.rdata[`KPS_ICTL_KPEN] = s_q.keypad_irq_enable;
            s_d.rsp.rdata[`KPS_ICTL_KPF] = s_q.keypad_irq_flag;
            s_d.clock_irq_flag = 1'b0;
            s_d.keypad_irq_flag = 1'b0;
         end else begin
            s_d.rsp.rresp = `KPS_RESP_SLVERR;
         end
      end
      s_d.rsp.arready = !s_d.rsp.rvalid;
      // Scanner: slots walked in order, limited by the clipped sizes
      col_n = kps_clip(s_d.column_count, `KPS_COL_MAX);
      row_n = kps_clip(s_d.row_count, `KPS_ROW_MAX);
      if (!s_d.auto_scan_enable) begin
         // Bypass: firmware scans, size and order have no effect
         s_d.slot = '0;
         s_d.column_drive = '0;
         s_d.row_enable = '0;
      end else begin
         if (s_d.slot >= col_n) begin
            s_d.slot = '0;
         end else if (scan_step_in) begin
            if (s_d.slot + 3'h1 >= col_n) begin
               s_d.slot = '0;
               ev[`KPS_EV_WRAP] = 1'b1;
            end else begin
               s_d.slot = s_d.slot + 3'h1;
            end
         end
         col_idx = kps_slot_col(s_d.order_low, s_d.order_high, s_d.slot);
         // Binary column index; an index beyond the last column drives none
         s_d.column_drive = (col_n != 3'h0 && col_idx < `KPS_COL_MAX) ? 5'(5'h01 << col_idx) : 5'h00;
         s_d.row_enable = 6'((7'h01 << row_n) - 7'h01);
      end
      // Event sets come last so they win over any clear
      ev[`KPS_EV_KEY] = key_found_in;
      ev[`KPS_EV_RTC] = clock_tick_in;
      if (key_found_in) begin
         s_d.key_found_flag = 1'b1;
         s_d.keypad_irq_flag = 1'b1;
      end
      if (clock_tick_in) begin
         s_d.clock_irq_flag = 1'b1;
      end
      s_d.irq_status = s_d.irq_status | ev;
      s_d.irq = (s_d.keypad_irq_flag & s_d.keypad_irq_enable)
              | (s_d.clock_irq_flag & s_d.clock_irq_enable)
              | (|(s_d.irq_status & s_d.irq_mask));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.row_count <= 3'(`KPS_RST_SIZE >> 3);
         s_q.column_count <= 3'(`KPS_RST_SIZE);
         s_q.order_low <= `KPS_RST_ORDL;
         s_q.order_high <= `KPS_RST_ORDH;
      end else begin
         s_q <= s_d;
      end
   end

   assign axi_rsp = s_q.rsp;
   assign column_drive = s_q.column_drive;
   assign row_enable = s_q.row_enable;
   assign irq = s_q.irq;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   bypass_idle_a: assert property (!s_q.auto_scan_enable |-> column_drive == '0 && row_enable == '0)
      else $error("scan outputs active in bypass mode");
   row_limit_a: assert property (s_q.auto_scan_enable |->
      $countones(row_enable) == kps_clip(s_q.row_count, `KPS_ROW_MAX))
      else $error("row enables do not match row count");
   slot_limit_a: assert property (s_q.auto_scan_enable && s_q.slot != 3'h0 |->
      s_q.slot < kps_clip(s_q.column_count, `KPS_COL_MAX))
      else $error("slot beyond column count");
   slot_map_a: assert property (column_drive != '0 |->
      column_drive == 5'(5'h01 << kps_slot_col(s_q.order_low, s_q.order_high, s_q.slot)))
      else $error("driven column differs from slot contents");
   step_adv_a: assert property (s_q.auto_scan_enable && scan_step_in && s_q.slot == 3'h0
      && s_q.column_count >= 3'h2 && !s_q.aw_got |=> s_q.slot == 3'h1)
      else $error("scan did not advance to the next slot");
   key_sets_a: assert property (key_found_in |=> s_q.keypad_irq_flag && s_q.key_found_flag)
      else $error("key event lost");
   rtc_sets_a: assert property (clock_tick_in |=> s_q.clock_irq_flag)
      else $error("clock event lost");
   ctl_rd_clear_a: assert property (rd_hs && rd_sel == KPS_SEL_ICTL && !key_found_in
      |=> !s_q.keypad_irq_flag ##0 s_q.rsp.rvalid)
      else $error("keypad flag not cleared by read");
   stat_rd_clear_a: assert property (rd_hs && rd_sel == KPS_SEL_STAT && !key_found_in |=> !s_q.key_found_flag)
      else $error("key found flag not cleared by read");
   kp_gate_a: assert property (s_q.keypad_irq_flag && !s_q.keypad_irq_enable && !s_q.clock_irq_flag
      && s_q.irq_mask == '0 |-> !irq)
      else $error("disabled keypad event raised interrupt");
   upper_zero_a: assert property (s_q.rsp.rvalid |-> s_q.rsp.rdata[31:8] == '0)
      else $error("unused read bits not zero");
   wr_resp_a: assert property (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid |=> s_q.rsp.bvalid)
      else $error("write response late");

   key_irq_c: cover property (key_found_in && s_q.keypad_irq_enable ##1 irq);
   wrap_c: cover property (s_q.auto_scan_enable && s_q.column_count == 3'h5 && s_q.slot == 3'h4 && scan_step_in);
   race_c: cover property (rd_hs && rd_sel == KPS_SEL_ICTL && key_found_in);
endmodule // kps_scan_ctrl
